// file: dv/i2c_master_model.sv
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// two-wire bus master: makes the bus clock, pulls data low, releases to pull-up
module i2c_master_model (
  // bus
  output logic      scl_clk,
  output logic      sda_low,
  input  wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;

  localparam int Q = 16;

  // clock and data idle high between frames
  initial
  begin
    scl_clk = 1'b1;
    sda_low = 1'b0;
  end

  // free clocks, only used around reset
  task automatic clocks(input int n);
    repeat (n)
    begin
      #(2*Q) scl_clk = 1'b0;
      #(2*Q) scl_clk = 1'b1;
    end
  endtask : clocks

  // start, or repeated start when the clock is low
  task automatic start_c();
    if (!scl_clk)
    begin
      #Q sda_low = 1'b0;
      #Q scl_clk = 1'b1;
    end
    #Q sda_low = 1'b1;
    #Q scl_clk = 1'b0;
  endtask : start_c

  // one bit: data set while clock low, sampled at the rise
  task automatic bit_c(input logic b, output logic s);
    #Q sda_low = !b;
    #Q scl_clk = 1'b1;
    s = sda;
    #(2*Q) scl_clk = 1'b0;
  endtask : bit_c

  // byte out, returns the slave acknowledge
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_c(b[i], s);
    bit_c(1'b1, s);
    ack = !s;
  endtask : wr_byte

  // byte in, then ack unless it is the last one
  task automatic rd_byte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_c(1'b1, b[i]);
    bit_c(last, s);
  endtask : rd_byte

  // stop: data rises while clock high, then the bus stands still
  task automatic stop_c();
    #Q sda_low = 1'b1;
    #Q scl_clk = 1'b1;
    #Q sda_low = 1'b0;
    #Q;
  endtask : stop_c

endmodule : i2c_master_model

`default_nettype wire

// file: dv/tb.sv
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// readback path bench
module tb;
  import readback_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic                            clk_sys, reset, scl_clk, sda_i, sda_o, sda_oe, sda_low;
  logic                            pin_addr_bit1, pin_addr_bit0, hold_readback;
  logic                            powerdown_mode_hi, powerdown_mode_lo, ctrl_stalled;
  logic [CHANNELS-1:0][CODE_W-1:0] chan_code;
  ctrl_s                           active_ctrl;
  logic [7:0]                      last_ctrl;
  int                              n_errors, checks, seed;

  // wire level: low if either side pulls, else pulled high
  assign sda_i = ~((sda_oe & ~sda_o) | sda_low);

  dac_i2c_readback dac_i2c_readback_i (
    .clk_sys, .reset, .scl_clk, .sda_i, .sda_o, .sda_oe, .pin_addr_bit1,
    .pin_addr_bit0, .chan_code, .powerdown_mode_hi, .powerdown_mode_lo,
    .hold_readback, .active_ctrl, .ctrl_stalled
  );

  i2c_master_model i2c_master_model_i (.scl_clk, .sda_low, .sda(sda_i));

  // system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // compare and count
  task automatic check(input string what, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // verdict and end of run
  task automatic summarize();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : summarize

  // expected bytes
  function automatic logic [7:0] pd_exp(input logic [1:0] m);
    return {m, PD_FILL};
  endfunction : pd_exp

  function automatic logic [7:0] addr_exp(input logic rw);
    return {ADDR_FIXED, pin_addr_bit1, pin_addr_bit0, rw};
  endfunction : addr_exp

  // random codes and straps, chosen mode
  task automatic set_inputs(input logic [1:0] m);
    @(posedge clk_sys);
    chan_code         <= 40'({$random(seed), $random(seed)});
    {pin_addr_bit1, pin_addr_bit0} <= 2'($random(seed));
    powerdown_mode_hi <= m[1];
    powerdown_mode_lo <= m[0];
    @(posedge clk_sys);
  endtask : set_inputs

  // start, write address, control byte
  task automatic ctrl_phase(input logic [7:0] ctrl);
    logic ack;
    i2c_master_model_i.start_c();
    i2c_master_model_i.wr_byte(addr_exp(1'b0), ack);
    check("write addr ack", ack, 1);
    i2c_master_model_i.wr_byte(ctrl, ack);
    check("ctrl ack", ack, 1);
    last_ctrl = ctrl;
  endtask : ctrl_phase

  // full readback of one channel
  task automatic xfer(input logic [1:0] sel, input logic flag, input logic endstop);
    logic       ack;
    logic [7:0] b, r;
    logic [9:0] code;
    r = 8'($random(seed));
    ctrl_phase({r[7:3], sel, flag});
    i2c_master_model_i.start_c();
    i2c_master_model_i.wr_byte(addr_exp(1'b1), ack);
    check("read addr ack", ack, 1);
    @(negedge clk_sys);
    check("active ctrl", active_ctrl, last_ctrl);
    code = chan_code[sel];
    if (flag)
    begin
      i2c_master_model_i.rd_byte(1'b0, b);
      check("pd byte", b, pd_exp({powerdown_mode_hi, powerdown_mode_lo}));
    end
    i2c_master_model_i.rd_byte(1'b0, b);
    check("hi byte", b, code[9:2]);
    i2c_master_model_i.rd_byte(1'b1, b);
    check("lo byte", b[7:6], code[1:0]);
    @(negedge clk_sys);
    check("data released", sda_oe, 0);
    if (endstop)
      i2c_master_model_i.stop_c();
  endtask : xfer

  // hang guard
  initial
  begin
    repeat (50000) @(posedge clk_sys);
    n_errors++;
    summarize();
  end

  // main sequence
  initial
  begin
    logic       ack;
    logic [7:0] keep;
    int         k;
    seed = 66840;
    n_errors = 0;
    checks = 0;
    reset = 1'b1;
    hold_readback = 1'b0;
    chan_code = '0;
    {pin_addr_bit1, pin_addr_bit0, powerdown_mode_hi, powerdown_mode_lo} = 4'h0;
    i2c_master_model_i.clocks(3);
    @(posedge clk_sys);
    reset <= 1'b0;
    i2c_master_model_i.clocks(3);
    @(negedge clk_sys);
    check("reset ctrl", active_ctrl, 0);
    check("reset sda", sda_oe, 0);
    check("reset sda value", sda_o, 0);
    check("reset stall", ctrl_stalled, 0);
    // every channel, both lengths, every mode, stop or repeated start
    for (int i = 0; i < 16; i++)
    begin
      set_inputs(2'(i >> 2) ^ 2'(i));
      xfer(2'(i), i[2], i[0]);
    end
    // foreign fixed part, then foreign strap pins: no ack
    for (int j = 0; j < 2; j++)
    begin
      set_inputs(2'h2);
      i2c_master_model_i.start_c();
      i2c_master_model_i.wr_byte(addr_exp(1'b0) ^ (j ? 8'h02 : 8'h80), ack);
      check("foreign ack", ack, 0);
      xfer(2'(j + 1), 1'b1, 1'b1);
    end
    // stalled draining: fill the fifo, then one more waits
    @(posedge clk_sys);
    hold_readback <= 1'b1;
    keep = active_ctrl;
    for (int j = 0; j < FIFO_DEPTH + 1; j++)
    begin
      ctrl_phase(8'($random(seed)));
      i2c_master_model_i.stop_c();
    end
    @(negedge clk_sys);
    check("stale ctrl", active_ctrl, keep);
    check("stalled", ctrl_stalled, 1);
    @(posedge clk_sys);
    hold_readback <= 1'b0;
    k = 0;
    while (active_ctrl !== last_ctrl && k < 400)
    begin
      @(posedge clk_sys);
      k++;
    end
    @(negedge clk_sys);
    check("latest ctrl", active_ctrl, last_ctrl);
    check("drained", ctrl_stalled, 0);
    set_inputs(2'h1);
    xfer(2'h3, 1'b1, 1'b1);
    summarize();
  end

endmodule : tb

`default_nettype wire

// file: rtl/dac_i2c_readback.sv
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// synchronous fifo with valid and ready on both sides
module ctrl_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         reset,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0]  mem [DEPTH];
  logic [PW-1:0] wr_reg;
  logic [PW-1:0] rd_reg;
  logic [CW-1:0] count_reg;
  logic          push;
  logic          pop;

  // handshakes and flags
  assign in_ready  = (count_reg != CW'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data  = mem[rd_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // storage
  always_ff @(posedge clk_sys)
  begin
    if (push)
      mem[wr_reg] <= in_data;
  end

  // pointers and fill level
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      wr_reg    <= '0;
      rd_reg    <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (push)
        wr_reg <= (wr_reg == PW'(DEPTH - 1)) ? '0 : wr_reg + PW'(1);
      if (pop)
        rd_reg <= (rd_reg == PW'(DEPTH - 1)) ? '0 : rd_reg + PW'(1);
      if (push && !pop)
        count_reg <= count_reg + CW'(1);
      else if (pop && !push)
        count_reg <= count_reg - CW'(1);
    end
  end

endmodule : ctrl_fifo

////////////////////////////////////////////////////////////////////////////////
// two-wire slave readback path
module dac_i2c_readback (
  // system side
  input  wire logic                   clk_sys,
  input  wire logic                   reset,
  // two-wire link
  input  wire logic                   scl_clk,
  input  wire logic                   sda_i,
  output logic                        sda_o,
  output logic                        sda_oe,
  // address pins
  input  wire logic                   pin_addr_bit1,
  input  wire logic                   pin_addr_bit0,
  // channel contents and readback hold
  input  wire logic [readback_pkg::CHANNELS-1:0][readback_pkg::CODE_W-1:0] chan_code,
  input  wire logic                   powerdown_mode_hi,
  input  wire logic                   powerdown_mode_lo,
  input  wire logic                   hold_readback,
  // status
  output readback_pkg::ctrl_s         active_ctrl,
  output logic                        ctrl_stalled
);
  import readback_pkg::*;

  logic        rst_l1;
  logic        rst_l2;
  logic [1:0]  pin_addr;
  logic        sda_pos_reg;
  link_state_e st_reg;
  link_state_e st_next;
  logic [2:0]  cnt_reg;
  logic [2:0]  cnt_next;
  logic [7:0]  sh_reg;
  logic [7:0]  sh_next;
  logic [7:0]  tx_reg;
  logic [7:0]  tx_next;
  logic [1:0]  left_reg;
  logic [1:0]  left_next;
  logic        rw_reg;
  logic        rw_next;
  logic        oe_next;
  logic        ctrl_fire;
  logic [7:0]  rx;
  logic        bus_edge;
  ctrl_s       ctrl_word_reg;
  logic        ctrl_tgl_reg;
  logic        tgl_s1;
  logic        tgl_s2;
  logic        tgl_s3;
  logic        ctrl_evt;
  ctrl_s       pend_data_reg;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  ctrl_s       fifo_out;
  logic        pop;
  logic [CODE_W-1:0] chan_pick;
  resp_s       resp_reg;
  logic [1:0]  pin_addr_s1;

  //////////////////////////////////////////////////////////////////////////////
  // link domain: reset and address pins
  always_ff @(negedge scl_clk)
  begin
    rst_l1 <= reset;
    rst_l2 <= rst_l1;
  end

  // address straps pass two flops
  always_ff @(negedge scl_clk)
  begin
    pin_addr_s1 <= {pin_addr_bit1, pin_addr_bit0};
    pin_addr    <= pin_addr_s1;
  end

  // data sampled while the clock is high
  always_ff @(posedge scl_clk)
  begin
    if (rst_l2)
      sda_pos_reg <= 1'b1;
    else
      sda_pos_reg <= sda_i;
  end

  assign rx       = {sh_reg[6:0], sda_pos_reg};
  assign bus_edge = (sda_pos_reg != sda_i);

  // byte engine, stepped on the falling clock
  always_comb
  begin
    st_next   = st_reg;
    cnt_next  = cnt_reg;
    sh_next   = sh_reg;
    tx_next   = tx_reg;
    left_next = left_reg;
    rw_next   = rw_reg;
    oe_next   = sda_oe;
    ctrl_fire = 1'b0;
    if (sda_pos_reg && !sda_i)
    begin
      st_next  = L_ADDR; // start or repeated start
      cnt_next = CNT_RST;
      oe_next  = 1'b0;
    end
    else if (!sda_pos_reg && sda_i)
    begin
      st_next = L_IDLE; // stop
      oe_next = 1'b0;
    end
    else
    begin
      case (st_reg)
        L_IDLE:
        begin
          st_next  = L_ADDR; // a falling clock here follows a start
          cnt_next = CNT_RST;
        end
        L_ADDR:
        begin
          sh_next  = rx;
          cnt_next = cnt_reg + 3'h1;
          if (cnt_reg == BIT_LAST)
          begin
            if (rx[7:1] == {ADDR_FIXED, pin_addr})
            begin
              oe_next = 1'b1;
              rw_next = rx[0];
              st_next = L_AACK;
            end
            else
              st_next = L_SKIP;
          end
        end
        L_AACK:
        begin
          cnt_next = CNT_RST;
          if (rw_reg)
          begin
            tx_next   = resp_reg.three ? resp_reg.pd_byte : resp_reg.hi_byte;
            left_next = resp_reg.three ? BYTES_PD - 2'h1 : BYTES_PLAIN - 2'h1;
            oe_next   = !tx_next[7];
            st_next   = L_TX;
          end
          else
          begin
            oe_next = 1'b0;
            st_next = L_CTRL;
          end
        end
        L_CTRL:
        begin
          sh_next  = rx;
          cnt_next = cnt_reg + 3'h1;
          if (cnt_reg == BIT_LAST)
          begin
            oe_next   = 1'b1;
            ctrl_fire = 1'b1;
            st_next   = L_CACK;
          end
        end
        L_CACK:
        begin
          oe_next = 1'b0;
          st_next = L_IDLE;
        end
        L_SKIP:
          oe_next = 1'b0;
        L_TX:
        begin
          cnt_next = cnt_reg + 3'h1;
          if (cnt_reg == BIT_LAST)
          begin
            oe_next = 1'b0;
            st_next = L_TACK;
          end
          else
          begin
            tx_next = {tx_reg[6:0], 1'b0};
            oe_next = !tx_reg[6];
          end
        end
        L_TACK:
        begin
          cnt_next = CNT_RST;
          if (!sda_pos_reg && left_reg != 2'h0)
          begin
            tx_next   = (left_reg == 2'h2) ? resp_reg.hi_byte : resp_reg.lo_byte;
            left_next = left_reg - 2'h1;
            oe_next   = !tx_next[7];
            st_next   = L_TX;
          end
          else
          begin
            oe_next = 1'b0; // release after not-ack
            st_next = L_IDLE;
          end
        end
        default:
        begin
          oe_next = 1'b0;
          st_next = L_IDLE;
        end
      endcase
    end
  end

  // link state registers
  always_ff @(negedge scl_clk)
  begin
    if (rst_l2)
    begin
      st_reg   <= L_IDLE;
      cnt_reg  <= CNT_RST;
      sh_reg   <= BYTE_RST;
      tx_reg   <= BYTE_RST;
      left_reg <= 2'h0;
      rw_reg   <= 1'b0;
    end
    else
    begin
      st_reg   <= st_next;
      cnt_reg  <= cnt_next;
      sh_reg   <= sh_next;
      tx_reg   <= tx_next;
      left_reg <= left_next;
      rw_reg   <= rw_next;
    end
  end

  // pin drive, changed only while the clock is low
  always_ff @(negedge scl_clk)
  begin
    sda_o <= 1'b0;
    if (rst_l2)
      sda_oe <= 1'b0;
    else
      sda_oe <= oe_next;
  end

  // control byte handed over with a toggle
  always_ff @(negedge scl_clk)
  begin
    if (rst_l2)
    begin
      ctrl_word_reg <= CTRL_RST;
      ctrl_tgl_reg  <= 1'b0;
    end
    else if (ctrl_fire)
    begin
      ctrl_word_reg <= ctrl_s'(rx);
      ctrl_tgl_reg  <= !ctrl_tgl_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // system domain: toggle synchroniser
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      tgl_s1 <= 1'b0;
      tgl_s2 <= 1'b0;
      tgl_s3 <= 1'b0;
    end
    else
    begin
      tgl_s1 <= ctrl_tgl_reg;
      tgl_s2 <= tgl_s1;
      tgl_s3 <= tgl_s2;
    end
  end

  assign ctrl_evt = tgl_s2 ^ tgl_s3;

  // holding slot in front of the fifo; a new byte wins over acceptance
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      ctrl_stalled  <= 1'b0;
      pend_data_reg <= CTRL_RST;
    end
    else if (ctrl_evt)
    begin
      ctrl_stalled  <= 1'b1;
      pend_data_reg <= ctrl_word_reg;
    end
    else if (fifo_in_ready)
      ctrl_stalled <= 1'b0;
  end

  ctrl_fifo #(
    .W     ($bits(ctrl_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .in_valid  (ctrl_stalled),
    .in_ready  (fifo_in_ready),
    .in_data   (pend_data_reg),
    .out_valid (fifo_out_valid),
    .out_ready (!hold_readback),
    .out_data  (fifo_out)
  );

  assign pop       = fifo_out_valid && !hold_readback;
  assign chan_pick = chan_code[fifo_out.buf_sel];

  // oldest queued control byte, popped from the fifo, selects the channel and the format
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      active_ctrl <= CTRL_RST;
      resp_reg    <= RESP_RST;
    end
    else if (pop)
    begin
      active_ctrl      <= fifo_out;
      resp_reg.pd_byte <= {powerdown_mode_hi, powerdown_mode_lo, PD_FILL};
      resp_reg.hi_byte <= chan_pick[9:2];
      resp_reg.lo_byte <= {chan_pick[1:0], LO_FILL};
      resp_reg.three   <= fifo_out.powerdown_data_flag;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks on the link side
  addr_ack_a : assert property (
    @(negedge scl_clk) disable iff (rst_l2)
    (st_reg == L_ADDR && cnt_reg == BIT_LAST && !bus_edge
      && rx[7:1] == {ADDR_FIXED, pin_addr}) |=> (sda_oe && st_reg == L_AACK))
    else $error("matching address not acknowledged");

  addr_skip_a : assert property (
    @(negedge scl_clk) disable iff (rst_l2)
    (st_reg == L_ADDR && cnt_reg == BIT_LAST && !bus_edge
      && rx[7:1] != {ADDR_FIXED, pin_addr}) |=> (!sda_oe [*2]))
    else $error("foreign address acknowledged");

  ctrl_ack_a : assert property (
    @(negedge scl_clk) disable iff (rst_l2)
    (st_reg == L_CTRL && cnt_reg == BIT_LAST && !bus_edge) |=> sda_oe ##1 !sda_oe)
    else $error("control byte ack wrong");

  first_byte_a : assert property (
    @(negedge scl_clk) disable iff (rst_l2)
    (st_reg == L_AACK && rw_reg && !bus_edge) |=>
      (tx_reg == (resp_reg.three ? resp_reg.pd_byte : resp_reg.hi_byte)
       && left_reg == (resp_reg.three ? 2'h2 : 2'h1)))
    else $error("wrong first readback byte");

  bit_drive_a : assert property (
    @(negedge scl_clk) disable iff (rst_l2)
    (st_reg == L_TX) |-> (sda_oe == !tx_reg[7]))
    else $error("data line does not follow byte");

  nack_end_a : assert property (
    @(negedge scl_clk) disable iff (rst_l2)
    (st_reg == L_TACK && sda_pos_reg && !bus_edge) |=> (st_reg == L_IDLE && !sda_oe))
    else $error("line not released after not-ack");

  // checks on the system side
  sel_pick_a : assert property (
    @(posedge clk_sys) disable iff (reset)
    pop |=> (active_ctrl == $past(fifo_out)))
    else $error("selection not taken from control byte");

  data_bytes_a : assert property (
    @(posedge clk_sys) disable iff (reset)
    pop |=> ({resp_reg.hi_byte, resp_reg.lo_byte[7:6]} == $past(chan_pick)))
    else $error("data bytes do not carry the code");

  pd_byte_a : assert property (
    @(posedge clk_sys) disable iff (reset)
    pop |=> (resp_reg.pd_byte[5:0] == PD_FILL
      && resp_reg.pd_byte[7:6] == {$past(powerdown_mode_hi), $past(powerdown_mode_lo)}))
    else $error("power-down byte malformed");

  // main scenarios
  three_read_c : cover property (
    @(negedge scl_clk) disable iff (rst_l2) (st_reg == L_TACK && left_reg == 2'h2));
  two_read_c : cover property (
    @(negedge scl_clk) disable iff (rst_l2) (st_reg == L_AACK && rw_reg && !resp_reg.three));
  ctrl_seen_c : cover property (
    @(posedge clk_sys) disable iff (reset) ctrl_evt);
  fifo_full_c : cover property (
    @(posedge clk_sys) disable iff (reset) !fifo_in_ready);

endmodule : dac_i2c_readback

`default_nettype wire

// file: rtl/readback_pkg.sv
`default_nettype none

package readback_pkg;

  localparam int          CHANNELS    = 4;
  localparam int          CODE_W      = 10;
  localparam int          FIFO_DEPTH  = 8;
  localparam logic [4:0]  ADDR_FIXED  = 5'h13;
  localparam logic [2:0]  BIT_LAST    = 3'h7;
  localparam logic [2:0]  CNT_RST     = 3'h0;
  localparam logic [5:0]  PD_FILL     = 6'h3f;
  localparam logic [5:0]  LO_FILL     = 6'h00;
  localparam logic [1:0]  BYTES_PLAIN = 2'h2;
  localparam logic [1:0]  BYTES_PD    = 2'h3;
  localparam logic [7:0]  BYTE_RST    = 8'h00;

  // control byte, top bit first
  typedef struct packed {
    logic       ext_addr_bit3;
    logic       ext_addr_bit2;
    logic [1:0] load;
    logic       spare;
    logic [1:0] buf_sel;
    logic       powerdown_data_flag;
  } ctrl_s;

  localparam ctrl_s CTRL_RST = '0;

  // bytes prepared for the next readback
  typedef struct packed {
    logic [7:0] pd_byte;
    logic [7:0] hi_byte;
    logic [7:0] lo_byte;
    logic       three;
  } resp_s;

  localparam resp_s RESP_RST = '0;

  typedef enum logic [2:0] {
    L_IDLE,
    L_ADDR,
    L_AACK,
    L_CTRL,
    L_CACK,
    L_SKIP,
    L_TX,
    L_TACK
  } link_state_e;

endpackage : readback_pkg

`default_nettype wire
